// ### dv/cdu_power_stage.sv
`timescale 1ns/10ps
// ==========================================================
// Power stage model
module cdu_power_stage (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Gate drives
  input  wire logic primary_drive,
  input  wire logic compl_drive,
  // Fault flag
  output logic      shoot_q
);
  // Both switches on shorts the rail; sticky so the bench sees a one-cycle overlap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shoot_q <= 1'b0;
    end else if (primary_drive && compl_drive) begin
      shoot_q <= 1'b1;
    end
  end
endmodule : cdu_power_stage

// ### dv/test_complementary_drive_deadband_blanking.sv
`timescale 1ns/10ps
// ==========================================================
// Bench top
module test_complementary_drive_deadband_blanking
  import cdu_pkg::*;
;
  localparam int CW = 6;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pins;
  logic        primary_drive;
  logic        compl_drive;
  logic        shoot_q;
  int          fail_count;
  int          compares;

  cdu_core #(.CNT_W(CW)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rise_src_pin(pins[0]),
    .fall_src_pin(pins[1]), .primary_drive(primary_drive), .compl_drive(compl_drive)
  );
  cdu_power_stage i_stage (
    .pclk(pclk), .presetn(presetn), .primary_drive(primary_drive),
    .compl_drive(compl_drive), .shoot_q(shoot_q)
  );

  // ==========================================================
  // Common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic give_up();
    fail_count++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask : give_up

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) give_up();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, e);
    check(err, ee);
  endtask : rdchk

  // Disabling first clears drives so every scenario starts from rest
  task automatic cfg(input int rdb, fdb, rbk, fbk, rph, fph,
                     input logic mode, input logic [1:0] ctl);
    wr(CDU_ADDR_CTRL, 32'h0);
    wr(CDU_ADDR_RSRC_MDE, {31'h0, mode});
    wr(CDU_ADDR_RDB, rdb);
    wr(CDU_ADDR_FDB, fdb);
    wr(CDU_ADDR_RBLK, rbk);
    wr(CDU_ADDR_FBLK, fbk);
    wr(CDU_ADDR_RPH, rph);
    wr(CDU_ADDR_FPH, fph);
    wr(CDU_ADDR_CTRL, {30'h0, ctl});
  endtask : cfg

  function automatic logic drv(input bit w);
    return w ? compl_drive : primary_drive;
  endfunction : drv

  task automatic set_pin(input bit w, input logic v);
    @(posedge pclk);
    pins[w] <= v;
  endtask : set_pin

  task automatic fire(input bit w);
    set_pin(w, 1'b1);
    repeat (3) @(posedge pclk);
    pins[w] <= 1'b0;
  endtask : fire

  task automatic wait_drv(input bit w, input logic v, output int n);
    n = 0;
    #1;
    while (drv(w) !== v) begin
      @(posedge pclk);
      #1;
      n++;
      if (n > 200) give_up();
    end
  endtask : wait_drv

  task automatic never(input bit w, input int cyc, output logic hi);
    hi = 1'b0;
    repeat (cyc) begin
      @(posedge pclk);
      #1;
      if (drv(w) === 1'b1) hi = 1'b1;
    end
  endtask : never

  // Cycles from pin rise to drive rise, dead-bands zero
  task automatic lat(input bit w, input int ph, input logic mode, output int n);
    cfg(0, 0, 0, 0, w ? 0 : ph, w ? ph : 0, mode, 2'h3);
    if (w) begin
      fire(0);
      wait_drv(0, 1'b1, n);
    end
    set_pin(w, 1'b1);
    wait_drv(w, 1'b1, n);
    set_pin(w, 1'b0);
  endtask : lat

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] rd;
    logic        err;
    // Reset values all zero
    for (int i = 0; i < 9; i++) rdchk(8'(i * 4), 32'h0, 1'b0);
    wr(CDU_ADDR_RSRC_MDE, 32'hffff_ffa5);
    rdchk(CDU_ADDR_RSRC_MDE, 32'h0000_00a5, 1'b0);
    wr(CDU_ADDR_RDB, 32'hffff_ffff);
    rdchk(CDU_ADDR_RDB, 32'((1 << CW) - 1), 1'b0);
    wr(CDU_ADDR_STAT, 32'h0000_003f);
    rdchk(CDU_ADDR_STAT, 32'h0, 1'b0);
    apb(1'b1, 8'h40, 32'h1234_5678, rd, err);
    check(err, 1'b1);
    rdchk(8'h40, 32'h0, 1'b1);
  endtask : t_regs

  task automatic t_dead();
    int n;
    cfg(4, 7, 0, 0, 0, 0, 1'b1, 2'h3);
    fire(0);
    wait_drv(0, 1'b1, n);
    set_pin(1, 1'b1);
    wait_drv(0, 1'b0, n);
    wait_drv(1, 1'b1, n);
    check(n, 7);
    set_pin(1, 1'b0);
    set_pin(0, 1'b1);
    wait_drv(1, 1'b0, n);
    wait_drv(0, 1'b1, n);
    check(n, 4);
    set_pin(0, 1'b0);
  endtask : t_dead

  task automatic t_phase();
    int a;
    int b;
    for (int w = 0; w < 2; w++) begin
      lat(w, 0, 1'b1, a);
      check(a <= 4, 1'b1);
      lat(w, 6, 1'b1, b);
      check(b - a, 6);
    end
    lat(0, 0, 1'b1, a);
    // Level mode ignores the phase count
    lat(0, 6, 1'b0, b);
    check(b <= a, 1'b1);
  endtask : t_phase

  task automatic t_src_off();
    logic hi;
    for (int m = 0; m < 2; m++) begin
      cfg(0, 0, 0, 0, 0, 0, m[0], 2'h1);
      fire(0);
      never(0, 20, hi);
      check(hi, 1'b0);
    end
  endtask : t_src_off

  // w=0: rising inputs under falling blanking; w=1 the mirror case
  task automatic t_blank(input bit w, input int cnt);
    logic hi;
    cfg(0, 0, w ? cnt : 0, w ? 0 : cnt, 0, 0, 1'b1, 2'h3);
    if (!w) fire(0);
    fire(!w);
    fire(w);
    never(w, 25, hi);
    check(hi, cnt == 0);
    fire(w);
    never(w, 25, hi);
    check(hi, 1'b1);
  endtask : t_blank

  // s is the drive that the late opposite event must suppress
  task automatic t_over(input bit s);
    int   n;
    logic hi;
    cfg(10, 10, 0, 0, 0, 0, 1'b1, 2'h3);
    if (s) begin
      fire(0);
      wait_drv(0, 1'b1, n);
    end
    fire(s);
    fire(!s);
    never(s, 40, hi);
    check(hi, 1'b0);
    check(drv(!s), 1'b1);
    rdchk(CDU_ADDR_STAT, s ? 32'h0000_0005 : 32'h0000_0002, 1'b0);
  endtask : t_over

  // ==========================================================
  // Clock, reset and sequence
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    fail_count = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins = 2'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_dead();
    t_phase();
    t_src_off();
    for (int w = 0; w < 2; w++) begin
      t_blank(w, 12);
      t_blank(w, 0);
      t_over(w);
    end
    // No overlap of the two drives anywhere in the run
    check(shoot_q, 1'b0);
    report_and_stop();
  end
endmodule : test_complementary_drive_deadband_blanking

// ### src/cdu_core.sv
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
// Function
// - Primary turns on only after rising dead-band, started by rising event output.
// - Complementary turns on only after falling dead-band, started by falling event output.
// - Falling event during rising dead-band suppresses primary, extends by falling dead-band.
// - Rising event during falling dead-band suppresses complementary, extends by rising dead-band.
// - Falling blank counter masks rising inputs; rising blank counter masks falling inputs.
// - Blanking counts clock periods from zero to programmed value, runs full length.
// - Falling-triggered blanking starts when rising event output goes false.
// - Rising-triggered blanking starts when falling event output goes false.
// - Falling blank count zero disables blanking; rising inputs pass straight through.
// - Rising blank count zero disables blanking; falling inputs pass straight through.
// - Blanking uncertainty from asynchronous sources at most one clock period.
// - Non-zero phase count delays the event by that many clock periods.
// - Phase count zero disables phase delay; event passes straight to output flop.
// - Source 0 edge mode: rising pin edge, phase delayed; level mode: immediate event.
// - Source 0 disabled: selected pin never produces a rising event; a phase delay already running when it is disabled still fires.
module cdu_core
  import cdu_pkg::*;
#(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Event source pins (asynchronous)
  input  wire logic             rise_src_pin,
  input  wire logic             fall_src_pin,
  // Drive outputs
  output logic                  primary_drive,
  output logic                  compl_drive
);

  // ==========================================================
  // Helpers
  function automatic logic cnt_last(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] val);
    cnt_last = (CNT_W'(cnt + 1'b1) == val);
  endfunction : cnt_last

  function automatic logic cnt_zero(input logic [CNT_W-1:0] val);
    cnt_zero = (val == '0);
  endfunction : cnt_zero

  // ==========================================================
  // Registers
  logic [CDU_CTRL_W-1:0] ctrl_q;
  logic [CDU_RSIM_W-1:0] rising_source_mode_reg_q;
  logic [CNT_W-1:0]      rise_dead_q;
  logic [CNT_W-1:0]      fall_dead_q;
  logic [CNT_W-1:0]      rising_blank_count_q;
  logic [CNT_W-1:0]      falling_blank_count_q;
  logic [CNT_W-1:0]      rising_phase_count_q;
  logic [CNT_W-1:0]      falling_phase_count_q;

  logic                  unit_en;
  logic                  rising_src0_enable;
  logic                  rising_src0_edge_mode;
  logic                  apb_wr;
  logic                  apb_setup;
  logic                  addr_hit;
  logic [CDU_STAT_W-1:0] status;

  // Core state
  logic                  rpin_s1_q, rpin_s2_q, rpin_prev_q;
  logic                  fpin_s1_q, fpin_s2_q, fpin_prev_q;
  logic                  fblk_run_q, rblk_run_q;
  logic [CNT_W-1:0]      fblk_cnt_q, rblk_cnt_q;
  logic                  rph_run_q, fph_run_q;
  logic [CNT_W-1:0]      rph_cnt_q, fph_cnt_q;
  logic                  evt_q;
  logic                  db_run_q;
  logic [CNT_W-1:0]      db_cnt_q, db_tgt_q;
  logic                  pri_q, cmp_q;

  logic                  rise_edge, fall_edge;
  logic                  rise_req_dly, rise_req_imm, fall_req;
  logic                  rise_fire, fall_fire, set_evt, clr_evt;

  assign unit_en               = ctrl_q[CDU_CTRL_EN];
  assign rising_src0_enable    = ctrl_q[CDU_CTRL_SRC0_EN];
  assign rising_src0_edge_mode = rising_source_mode_reg_q[CDU_RSIM_SRC0];

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign status    = {db_run_q, rblk_run_q, fblk_run_q, evt_q, cmp_q, pri_q};

  always_comb begin
    case (paddr)
      CDU_ADDR_CTRL, CDU_ADDR_RSRC_MDE, CDU_ADDR_RDB, CDU_ADDR_FDB,
      CDU_ADDR_RBLK, CDU_ADDR_FBLK, CDU_ADDR_RPH, CDU_ADDR_FPH,
      CDU_ADDR_STAT: addr_hit = 1'b1;
      default:       addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q                   <= CDU_CTRL_RST;
      rising_source_mode_reg_q <= CDU_RSIM_RST;
      rise_dead_q              <= '0;
      fall_dead_q              <= '0;
      rising_blank_count_q     <= '0;
      falling_blank_count_q    <= '0;
      rising_phase_count_q     <= '0;
      falling_phase_count_q    <= '0;
    end else if (apb_wr) begin
      case (paddr)
        CDU_ADDR_CTRL:     ctrl_q                   <= pwdata[CDU_CTRL_W-1:0];
        CDU_ADDR_RSRC_MDE: rising_source_mode_reg_q <= pwdata[CDU_RSIM_W-1:0];
        CDU_ADDR_RDB:      rise_dead_q              <= pwdata[CNT_W-1:0];
        CDU_ADDR_FDB:      fall_dead_q              <= pwdata[CNT_W-1:0];
        CDU_ADDR_RBLK:     rising_blank_count_q     <= pwdata[CNT_W-1:0];
        CDU_ADDR_FBLK:     falling_blank_count_q    <= pwdata[CNT_W-1:0];
        CDU_ADDR_RPH:      rising_phase_count_q     <= pwdata[CNT_W-1:0];
        CDU_ADDR_FPH:      falling_phase_count_q    <= pwdata[CNT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data captured in setup so it is a flop output in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (apb_setup && !pwrite) begin
      case (paddr)
        CDU_ADDR_CTRL:     prdata <= 32'(ctrl_q);
        CDU_ADDR_RSRC_MDE: prdata <= 32'(rising_source_mode_reg_q);
        CDU_ADDR_RDB:      prdata <= 32'(rise_dead_q);
        CDU_ADDR_FDB:      prdata <= 32'(fall_dead_q);
        CDU_ADDR_RBLK:     prdata <= 32'(rising_blank_count_q);
        CDU_ADDR_FBLK:     prdata <= 32'(falling_blank_count_q);
        CDU_ADDR_RPH:      prdata <= 32'(rising_phase_count_q);
        CDU_ADDR_FPH:      prdata <= 32'(falling_phase_count_q);
        CDU_ADDR_STAT:     prdata <= 32'(status);
        default:           prdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Pin synchronisers
  // two-flop sync
  // Costs two cycles of latency but bounds the blanking jitter to one period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpin_s1_q   <= 1'b0;
      rpin_s2_q   <= 1'b0;
      rpin_prev_q <= 1'b0;
      fpin_s1_q   <= 1'b0;
      fpin_s2_q   <= 1'b0;
      fpin_prev_q <= 1'b0;
    end else begin
      rpin_s1_q   <= rise_src_pin;
      rpin_s2_q   <= rpin_s1_q;
      rpin_prev_q <= rpin_s2_q;
      fpin_s1_q   <= fall_src_pin;
      fpin_s2_q   <= fpin_s1_q;
      fpin_prev_q <= fpin_s2_q;
    end
  end

  assign rise_edge = rpin_s2_q && !rpin_prev_q;
  assign fall_edge = fpin_s2_q && !fpin_prev_q;

  // ==========================================================
  // Input qualification
  // edge or level
  assign rise_req_dly = unit_en && rising_src0_enable && rising_src0_edge_mode
                        && rise_edge && !fblk_run_q && !evt_q;
  assign rise_req_imm = unit_en && rising_src0_enable && !rising_src0_edge_mode
                        && rpin_s2_q && !fblk_run_q && !evt_q;
  assign fall_req     = unit_en && fall_edge && !rblk_run_q && evt_q;

  // ==========================================================
  // Phase delay
  // phase counters
  assign rise_fire = rise_req_imm
                     || (rise_req_dly && cnt_zero(rising_phase_count_q))
                     || (rph_run_q && cnt_last(rph_cnt_q, rising_phase_count_q));
  assign fall_fire = (fall_req && cnt_zero(falling_phase_count_q))
                     || (fph_run_q && cnt_last(fph_cnt_q, falling_phase_count_q));
  assign set_evt   = rise_fire && !evt_q;
  assign clr_evt   = fall_fire && evt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rph_run_q <= 1'b0;
      rph_cnt_q <= '0;
    end else if (!unit_en || set_evt) begin
      rph_run_q <= 1'b0;
      rph_cnt_q <= '0;
    end else if (rise_req_dly && !cnt_zero(rising_phase_count_q) && !rph_run_q) begin
      rph_run_q <= 1'b1;
      rph_cnt_q <= '0;
    end else if (rph_run_q) begin
      rph_cnt_q <= CNT_W'(rph_cnt_q + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fph_run_q <= 1'b0;
      fph_cnt_q <= '0;
    end else if (!unit_en || clr_evt) begin
      fph_run_q <= 1'b0;
      fph_cnt_q <= '0;
    end else if (fall_req && !cnt_zero(falling_phase_count_q) && !fph_run_q) begin
      fph_run_q <= 1'b1;
      fph_cnt_q <= '0;
    end else if (fph_run_q) begin
      fph_cnt_q <= CNT_W'(fph_cnt_q + 1'b1);
    end
  end

  // ==========================================================
  // Event state: high after rising event, low after falling event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 1'b0;
    end else if (!unit_en) begin
      evt_q <= 1'b0;
    end else if (set_evt) begin
      evt_q <= 1'b1;
    end else if (clr_evt) begin
      evt_q <= 1'b0;
    end
  end

  // ==========================================================
  // Blanking counters
  // start on falling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fblk_run_q <= 1'b0;
      fblk_cnt_q <= '0;
    end else if (!unit_en) begin
      fblk_run_q <= 1'b0;
      fblk_cnt_q <= '0;
    end else if (clr_evt && !cnt_zero(falling_blank_count_q)) begin
      fblk_run_q <= 1'b1;
      fblk_cnt_q <= '0;
    end else if (fblk_run_q) begin
      fblk_run_q <= !cnt_last(fblk_cnt_q, falling_blank_count_q);
      fblk_cnt_q <= CNT_W'(fblk_cnt_q + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rblk_run_q <= 1'b0;
      rblk_cnt_q <= '0;
    end else if (!unit_en) begin
      rblk_run_q <= 1'b0;
      rblk_cnt_q <= '0;
    end else if (set_evt && !cnt_zero(rising_blank_count_q)) begin
      rblk_run_q <= 1'b1;
      rblk_cnt_q <= '0;
    end else if (rblk_run_q) begin
      rblk_run_q <= !cnt_last(rblk_cnt_q, rising_blank_count_q);
      rblk_cnt_q <= CNT_W'(rblk_cnt_q + 1'b1);
    end
  end

  // ==========================================================
  // Dead-band and drive flops
  // dead-band counter
  // reload on overlap
  // An overlapping event restarts the count with the new band's length, so a shorter new band can end before the first one would have
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_run_q <= 1'b0;
      db_cnt_q <= '0;
      db_tgt_q <= '0;
    end else if (!unit_en) begin
      db_run_q <= 1'b0;
      db_cnt_q <= '0;
      db_tgt_q <= '0;
    end else if (set_evt) begin
      db_run_q <= !cnt_zero(rise_dead_q);
      db_cnt_q <= '0;
      db_tgt_q <= rise_dead_q;
    end else if (clr_evt) begin
      db_run_q <= !cnt_zero(fall_dead_q);
      db_cnt_q <= '0;
      db_tgt_q <= fall_dead_q;
    end else if (db_run_q) begin
      db_run_q <= !cnt_last(db_cnt_q, db_tgt_q);
      db_cnt_q <= CNT_W'(db_cnt_q + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_q <= 1'b0;
      cmp_q <= 1'b0;
    end else if (!unit_en) begin
      pri_q <= 1'b0;
      cmp_q <= 1'b0;
    end else if (set_evt) begin
      cmp_q <= 1'b0;
      pri_q <= cnt_zero(rise_dead_q);
    end else if (clr_evt) begin
      pri_q <= 1'b0;
      cmp_q <= cnt_zero(fall_dead_q);
    end else if (db_run_q && cnt_last(db_cnt_q, db_tgt_q)) begin
      pri_q <= evt_q;
      cmp_q <= !evt_q;
    end
  end

  assign primary_drive = pri_q;
  assign compl_drive   = cmp_q;

  // ==========================================================
  // Assertions
  // check
  pri_after_band_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_evt && !cnt_zero(rise_dead_q) |=> !pri_q && !cmp_q && db_run_q)
    else $error("primary turned on inside rising dead-band");

  cmp_after_band_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_evt && !cnt_zero(fall_dead_q) |=> !pri_q && !cmp_q && db_run_q)
    else $error("complementary turned on inside falling dead-band");

  rise_fall_ovl_a: assert property (@(posedge pclk) disable iff (!presetn)
    db_run_q && evt_q && clr_evt |=> !pri_q && (db_tgt_q == $past(fall_dead_q)))
    else $error("falling overlap did not extend dead-band");

  fall_rise_ovl_a: assert property (@(posedge pclk) disable iff (!presetn)
    db_run_q && !evt_q && set_evt |=> !cmp_q && (db_tgt_q == $past(rise_dead_q)))
    else $error("rising overlap did not extend dead-band");

  blank_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    fblk_run_q |-> !set_evt)
    else $error("rising event set during falling blanking");

  // interval length
  // Counts run cycles so any programmed length is checked, not one fixed value
  logic [CNT_W-1:0] fblk_len_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fblk_len_q <= '0;
    end else if (!fblk_run_q) begin
      fblk_len_q <= '0;
    end else begin
      fblk_len_q <= CNT_W'(fblk_len_q + 1'b1);
    end
  end

  blank_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fblk_run_q) && unit_en && $stable(falling_blank_count_q)
    |-> fblk_len_q == falling_blank_count_q)
    else $error("falling blanking interval length wrong");

  fblk_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_evt && !cnt_zero(falling_blank_count_q) |=> fblk_run_q && fblk_cnt_q == '0)
    else $error("falling blanking did not start");

  rblk_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_evt && !cnt_zero(rising_blank_count_q) |=> rblk_run_q && rblk_cnt_q == '0)
    else $error("rising blanking did not start");

  fblk_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_zero(falling_blank_count_q) && ($past(falling_blank_count_q) == '0)
    && !$past(fblk_run_q) |-> !fblk_run_q)
    else $error("falling blanking ran with zero count");

  phase_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    rph_run_q && !cnt_last(rph_cnt_q, rising_phase_count_q) && unit_en
    |=> !evt_q || $past(evt_q))
    else $error("rising event before phase delay expired");

  src_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rising_src0_enable && !rph_run_q |-> !set_evt)
    else $error("disabled source produced rising request");

  excl_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(pri_q && cmp_q))
    else $error("both drives on");

  pri_on_c:  cover property (@(posedge pclk) disable iff (!presetn) $rose(pri_q));
  cmp_on_c:  cover property (@(posedge pclk) disable iff (!presetn) $rose(cmp_q));
  ovl_c:     cover property (@(posedge pclk) disable iff (!presetn) db_run_q && clr_evt);
  blank_c:   cover property (@(posedge pclk) disable iff (!presetn) fblk_run_q && rise_edge);

endmodule : cdu_core

// ### src/cdu_pkg.sv
package cdu_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] CDU_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] CDU_ADDR_RSRC_MDE = 8'h04;
  localparam logic [7:0] CDU_ADDR_RDB      = 8'h08;
  localparam logic [7:0] CDU_ADDR_FDB      = 8'h0c;
  localparam logic [7:0] CDU_ADDR_RBLK     = 8'h10;
  localparam logic [7:0] CDU_ADDR_FBLK     = 8'h14;
  localparam logic [7:0] CDU_ADDR_RPH      = 8'h18;
  localparam logic [7:0] CDU_ADDR_FPH      = 8'h1c;
  localparam logic [7:0] CDU_ADDR_STAT     = 8'h20;

  // ==========================================================
  // Field positions
  localparam int CDU_CTRL_EN      = 0;
  localparam int CDU_CTRL_SRC0_EN = 1;
  localparam int CDU_CTRL_W       = 2;
  localparam int CDU_RSIM_SRC0    = 0;
  localparam int CDU_RSIM_W       = 8;
  localparam int CDU_STAT_W       = 6;

  // ==========================================================
  // Reset values
  localparam logic [CDU_CTRL_W-1:0] CDU_CTRL_RST = 2'h0;
  localparam logic [CDU_RSIM_W-1:0] CDU_RSIM_RST = 8'h00;

  // ==========================================================
  // Timing
  localparam int CDU_CLK_MHZ = 200;

endpackage : cdu_pkg
